// [rtl/base_clock_ratio_sel_pkg.sv]
// Purpose: Shared constants and types for the async base clock selector
// Assumes: Block clock runs at 200 MHz
// Notes:   Accumulator increments give long-term pulse rate of rate times ratio
package base_clock_ratio_sel_pkg;
  localparam int          SEL_W          = 4;
  localparam int          SEL_MSB_POS    = 7;
  localparam int          ACC_W          = 32;
  localparam int          CLK_HZ         = 200_000_000;
  localparam logic [3:0]  SEL_RESET      = 4'h0;
  localparam logic [3:0]  SEL_EXT        = 4'h0;
  localparam logic [3:0]  SEL_TIMER      = 4'h4;
  localparam logic [1:0]  SEL_RSVD_TOP   = 2'h3;
  localparam logic        RATIO_16X      = 1'b0;
  localparam logic        RATIO_8X       = 1'b1;
  localparam int          TIMER_SYNC_N   = 3;
  // Average rates in bits per second
  localparam longint      RATE_0001_BPS  = 115152;
  localparam longint      RATE_0010_BPS  = 460606;
  localparam longint      RATE_0011_BPS  = 921569;
  localparam longint      RATE_0101_BPS  = 115196;
  localparam longint      RATE_0110_BPS  = 460784;
  localparam longint      RATE_0111_BPS  = 720000;
  localparam longint      RATE_1000_BPS  = 115132;
  localparam longint      RATE_1001_BPS  = 460526;
  localparam longint      RATE_1010_BPS  = 720000;
  localparam longint      RATE_1011_BPS  = 921053;

  // Phase increment for pulse rate = rate * mult, out of 2^ACC_W per block clock
  function automatic logic [ACC_W-1:0] inc_of(input longint rate, input longint mult);
    longint num;
    num = (rate * mult) << ACC_W;
    return ACC_W'(num / CLK_HZ);
  endfunction : inc_of

  typedef enum logic [1:0] {
    BASE_CLOCK_RATIO_SEL_SRC_EXT   = 2'h0,
    BASE_CLOCK_RATIO_SEL_SRC_AVG   = 2'h1,
    BASE_CLOCK_RATIO_SEL_SRC_TIMER = 2'h3,
    BASE_CLOCK_RATIO_SEL_SRC_RSVD  = 2'h2
  } base_clock_ratio_sel_src_t;

  typedef struct packed {
    base_clock_ratio_sel_src_t         src;
    logic              ratio_8x;
    logic [ACC_W-1:0]  inc;
  } base_clock_ratio_sel_cfg_t;

  typedef struct packed {
    logic ch0_a;
    logic ch0_c;
    logic ch1_a;
    logic ch2_a;
  } base_clock_ratio_sel_timer_t;
endpackage : base_clock_ratio_sel_pkg

// [rtl/base_clock_ratio_sel_accum.sv]
// Purpose: Fractional accumulator making base clock enable pulses
// Assumes: Increment is held steady while enabled
// Notes:   Carry out of the phase accumulator is the pulse
`timescale 1ns/1ps
module base_clock_ratio_sel_accum #(
  parameter int ACC_W = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             en_i,
  input  wire logic [ACC_W-1:0] inc_i,
  output logic                  pulse_o
);
  logic [ACC_W-1:0] phase_reg;
  logic [ACC_W:0]   sum;
  logic             pulse_reg;

  assign sum     = {1'b0, phase_reg} + {1'b0, inc_i};
  assign pulse_o = pulse_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= '0;
      pulse_reg <= 1'b0;
    end else if (en_i) begin
      phase_reg <= sum[ACC_W-1:0];
      pulse_reg <= sum[ACC_W];
    end else begin
      phase_reg <= '0;
      pulse_reg <= 1'b0;
    end
  end
endmodule : base_clock_ratio_sel_accum

// [rtl/base_clock_ratio_sel_top.sv]
// Purpose: Clock source and average rate selector for serial channel zero
// Assumes: Select bits are steady register outputs on the block clock
// Notes:   Timer outputs and the external clock are pins, synchronised here
// How it works
// - Select is four bits; msb from ext_mode_reg_b bit 7, three low bits.
// - Select 0000 takes base clock from external clock input.
// - 0001 gives 115.152 kbps at 16x, for 10.667 MHz only.
// - 0010 gives 460.606 kbps at 8x, for 10.667 MHz only.
// - 0011 gives 921.569 kbps at 8x, for 16 MHz only.
// - 0100 builds base clock from the four timer compare or PWM outputs.
// - 0101 gives 115.196 kbps at 16x, for 16 MHz only.
// - 0110 gives 460.784 kbps at 8x, for 16 MHz only.
// - 720 kbps at 8x via 0111 at 16 MHz or 1010 at 24 MHz.
// - 1000 gives 115.132 kbps at 16x, for 24 MHz only.
// - 1001 gives 460.526 kbps at 16x, for 24 MHz only.
// - 1011 gives 921.053 kbps at 8x, for 24 MHz only.
// - base_clock_ratio_sel 0 means 16x, 1 means 8x, in async mode.
`timescale 1ns/1ps
module base_clock_ratio_sel_top
  import base_clock_ratio_sel_pkg::*;
#(
  parameter int ACC_BITS = ACC_W
) (
  input  wire logic                 CORE_CLK_I,
  input  wire logic                 RST_N_I,
  input  wire logic                 ASYNC_SRC_SEL_MSB_I,
  input  wire logic [2:0]           ASYNC_SRC_SEL_LOW_I,
  input  wire logic                 BASE_CLOCK_RATIO_SEL_I,
  input  wire logic                 EXT_CLOCK_INPUT_SEL_I,
  input  wire logic                 SYNC_ASYNC_SELECT_I,
  input  wire logic                 EXT_CLK_PIN_I,
  input  wire base_clock_ratio_sel_pkg::base_clock_ratio_sel_timer_t TIMER_OUT_I,
  output logic                      BASE_CLK_EN_O,
  output logic                      RATIO_8X_O,
  output logic                      TIMER_SRC_ACTIVE_O,
  output logic                      SEL_RESERVED_O,
  output logic [3:0]                ASYNC_SRC_SEL_O
);
  import base_clock_ratio_sel_pkg::*;

  logic [1:0]              rst_sync_reg;
  logic                    rst_n;
  localparam int           PIN_N     = $bits(base_clock_ratio_sel_timer_t) + 1;
  localparam int           PRIME_END = TIMER_SYNC_N + 1;

  logic [PIN_N-1:0]        pin_raw;
  wire  [PIN_N-1:0]        pin_lvl;
  wire  [PIN_N-1:0]        pin_next;
  logic [2:0]              prime_reg;
  logic                    primed;
  base_clock_ratio_sel_timer_t             tmr_lvl_t;
  base_clock_ratio_sel_timer_t             tmr_next_t;
  logic                    ext_lvl;
  logic                    tmr_lvl;
  logic                    pulse_reg;
  logic                    ratio_reg;
  logic                    rsvd_reg;
  logic                    tmr_act_reg;
  logic [3:0]              sel_reg;
  logic [3:0]              sel;
  logic                    src_ext;
  logic                    src_avg;
  logic                    src_timer;
  logic                    pulse_next;
  logic                    ext_lvl_next;
  logic                    tmr_lvl_next;
  logic                    ext_rise;
  logic                    tmr_rise;
  logic                    acc_pulse;
  logic                    async_ext;
  base_clock_ratio_sel_cfg_t               cfg;

  // Reset released through two flip-flops
  assign rst_n = rst_sync_reg[1];
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign sel = {ASYNC_SRC_SEL_MSB_I, ASYNC_SRC_SEL_LOW_I};

  // Pins are synchronised one by one before any combining, so no glitch is sampled
  assign pin_raw = {EXT_CLK_PIN_I, TIMER_OUT_I};

  // Decode of select to source, ratio and increment
  always_comb begin
    cfg.src      = BASE_CLOCK_RATIO_SEL_SRC_AVG;
    cfg.ratio_8x = RATIO_8X;
    cfg.inc      = '0;
    unique case (sel)
      4'h0: begin
        cfg.src      = BASE_CLOCK_RATIO_SEL_SRC_EXT;
        cfg.ratio_8x = BASE_CLOCK_RATIO_SEL_I;
      end
      4'h1: begin
        cfg.ratio_8x = RATIO_16X;
        cfg.inc      = inc_of(RATE_0001_BPS, 16);
      end
      4'h2: cfg.inc = inc_of(RATE_0010_BPS, 8);
      4'h3: cfg.inc = inc_of(RATE_0011_BPS, 8);
      4'h4: begin
        cfg.src      = BASE_CLOCK_RATIO_SEL_SRC_TIMER;
        cfg.ratio_8x = BASE_CLOCK_RATIO_SEL_I;
      end
      4'h5: begin
        cfg.ratio_8x = RATIO_16X;
        cfg.inc      = inc_of(RATE_0101_BPS, 16);
      end
      4'h6: cfg.inc = inc_of(RATE_0110_BPS, 8);
      4'h7: cfg.inc = inc_of(RATE_0111_BPS, 8);
      4'h8: begin
        cfg.ratio_8x = RATIO_16X;
        cfg.inc      = inc_of(RATE_1000_BPS, 16);
      end
      4'h9: begin
        cfg.ratio_8x = RATIO_16X;
        cfg.inc      = inc_of(RATE_1001_BPS, 16);
      end
      4'hA: cfg.inc = inc_of(RATE_1010_BPS, 8);
      4'hB: cfg.inc = inc_of(RATE_1011_BPS, 8);
      default: begin
        cfg.src      = BASE_CLOCK_RATIO_SEL_SRC_RSVD;
        cfg.ratio_8x = BASE_CLOCK_RATIO_SEL_I;
      end
    endcase
  end

  // Source only acts with external clock chosen in asynchronous mode
  assign async_ext = EXT_CLOCK_INPUT_SEL_I & ~SYNC_ASYNC_SELECT_I;

  // Source decode
  assign src_ext   = (cfg.src == BASE_CLOCK_RATIO_SEL_SRC_EXT);
  assign src_avg   = (cfg.src == BASE_CLOCK_RATIO_SEL_SRC_AVG);
  assign src_timer = (cfg.src == BASE_CLOCK_RATIO_SEL_SRC_TIMER);

  // Fractional accumulator for the average-rate encodings

  base_clock_ratio_sel_accum #(
    .ACC_W (ACC_BITS)
  ) u_accum (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (rst_n),
    .en_i    (async_ext && src_avg),
    .inc_i   (ACC_BITS'(cfg.inc)),
    .pulse_o (acc_pulse)
  );

  // Pin inputs: three stages each, change counted when stages two and three agree
  for (genvar p = 0; p < PIN_N; p++) begin : g_pin
    logic [TIMER_SYNC_N-1:0] sync_reg;
    logic                    lvl_reg;
    logic                    lvl_next;

    assign lvl_next    = (sync_reg[TIMER_SYNC_N-2] == sync_reg[TIMER_SYNC_N-1])
                       ? sync_reg[TIMER_SYNC_N-1] : lvl_reg;
    assign pin_lvl[p]  = lvl_reg;
    assign pin_next[p] = lvl_next;

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
        sync_reg <= '0;
        lvl_reg  <= 1'b0;
      end else begin
        sync_reg <= {sync_reg[TIMER_SYNC_N-2:0], pin_raw[p]};
        lvl_reg  <= lvl_next;
      end
    end
  end

  // Edges count only once every synchroniser has filled, so idle-high pins make none
  assign primed = (prime_reg == 3'(PRIME_END));

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      prime_reg <= 3'h0;
    end else begin
      prime_reg <= primed ? prime_reg : prime_reg + 3'h1;
    end
  end

  // Gate of settled timer levels forming the timer base clock
  assign tmr_lvl_t    = base_clock_ratio_sel_timer_t'(pin_lvl[PIN_N-2:0]);
  assign tmr_next_t   = base_clock_ratio_sel_timer_t'(pin_next[PIN_N-2:0]);
  assign tmr_lvl      = (tmr_lvl_t.ch0_a | tmr_lvl_t.ch0_c)
                      ^ (tmr_lvl_t.ch1_a & tmr_lvl_t.ch2_a);
  assign tmr_lvl_next = (tmr_next_t.ch0_a | tmr_next_t.ch0_c)
                      ^ (tmr_next_t.ch1_a & tmr_next_t.ch2_a);
  assign ext_lvl      = pin_lvl[PIN_N-1];
  assign ext_lvl_next = pin_next[PIN_N-1];
  assign ext_rise     = primed & ext_lvl_next & ~ext_lvl;
  assign tmr_rise     = primed & tmr_lvl_next & ~tmr_lvl;

  // Base clock enable from the chosen source
  assign pulse_next = src_ext   ? (async_ext & ext_rise)
                    : src_avg   ? acc_pulse
                    : src_timer ? (async_ext & tmr_rise)
                    : 1'b0;

  // Registered outputs
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pulse_reg   <= 1'b0;
      ratio_reg   <= RATIO_16X;
      rsvd_reg    <= 1'b0;
      tmr_act_reg <= 1'b0;
      sel_reg     <= SEL_RESET;
    end else begin
      pulse_reg   <= pulse_next;
      ratio_reg   <= cfg.ratio_8x;
      rsvd_reg    <= (sel[3:2] == SEL_RSVD_TOP);
      tmr_act_reg <= async_ext && src_timer;
      sel_reg     <= sel;
    end
  end

  assign BASE_CLK_EN_O      = pulse_reg;
  assign RATIO_8X_O         = ratio_reg;
  assign SEL_RESERVED_O     = rsvd_reg;
  assign TIMER_SRC_ACTIVE_O = tmr_act_reg;
  assign ASYNC_SRC_SEL_O    = sel_reg;
endmodule : base_clock_ratio_sel_top

// [tb/base_clock_ratio_sel_asserts.sv]
// Purpose: Port checks for base_clock_ratio_sel_top
// Assumes: Select held steady between changes
// Notes:   Checks other than a_off, a_rsvoff and a_one start four edges after reset
`timescale 1ns/1ps
module base_clock_ratio_sel_asserts
  import base_clock_ratio_sel_pkg::*;
(
  input wire logic        CORE_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        ASYNC_SRC_SEL_MSB_I,
  input wire logic [2:0]  ASYNC_SRC_SEL_LOW_I,
  input wire logic        BASE_CLOCK_RATIO_SEL_I,
  input wire logic        EXT_CLOCK_INPUT_SEL_I,
  input wire logic        SYNC_ASYNC_SELECT_I,
  input wire logic        EXT_CLK_PIN_I,
  input wire base_clock_ratio_sel_timer_t TIMER_OUT_I,
  input wire logic        BASE_CLK_EN_O,
  input wire logic        RATIO_8X_O,
  input wire logic        TIMER_SRC_ACTIVE_O,
  input wire logic        SEL_RESERVED_O,
  input wire logic [3:0]  ASYNC_SRC_SEL_O
);
  logic [2:0] up_reg;
  wire [3:0] sel = {ASYNC_SRC_SEL_MSB_I, ASYNC_SRC_SEL_LOW_I};
  wire       ok  = up_reg == 3'h4;
  wire       run = EXT_CLOCK_INPUT_SEL_I && !SYNC_ASYNC_SELECT_I;
  wire       tmr = (TIMER_OUT_I.ch0_a | TIMER_OUT_I.ch0_c)
                   ^ (TIMER_OUT_I.ch1_a & TIMER_OUT_I.ch2_a);
  wire       r8  = ((sel & 4'hB) == 4'h0) ? BASE_CLOCK_RATIO_SEL_I
                   : (sel inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB});
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) up_reg <= 3'h0;
    else if (!ok) up_reg <= up_reg + 3'h1;
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_sel; ok |-> ASYNC_SRC_SEL_O == $past(sel); endproperty
  a_sel: assert property (p_sel) else $error("select copy wrong");
  property p_rsv; ok |-> SEL_RESERVED_O == ($past(sel[3:2]) == 2'h3); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
  property p_ratio; ok && $past(sel[3:2]) != 2'h3 |-> RATIO_8X_O == $past(r8); endproperty
  a_ratio: assert property (p_ratio) else $error("ratio wrong");
  property p_tact; ok && $past(run) |-> TIMER_SRC_ACTIVE_O == ($past(sel) == 4'h4); endproperty
  a_tact: assert property (p_tact) else $error("timer flag wrong");
  property p_off; (!run)[*8] |-> !BASE_CLK_EN_O; endproperty
  a_off: assert property (p_off) else $error("pulse while refused");
  property p_rsvoff; (sel[3:2] == 2'h3)[*8] |-> !BASE_CLK_EN_O; endproperty
  a_rsvoff: assert property (p_rsvoff) else $error("pulse on reserved");
  property p_one; BASE_CLK_EN_O |=> !BASE_CLK_EN_O; endproperty
  a_one: assert property (p_one) else $error("pulse too long");
  property p_ext; ok && run && sel == 4'h0 && $rose(EXT_CLK_PIN_I) |-> ##[2:5] BASE_CLK_EN_O;
  endproperty
  a_ext: assert property (p_ext) else $error("no pulse from pin");
  property p_tmr; ok && run && sel == 4'h4 && $rose(tmr) |-> ##[2:5] BASE_CLK_EN_O; endproperty
  a_tmr: assert property (p_tmr) else $error("no pulse from timer");
  c_avg: cover property (run && sel == 4'h1 && BASE_CLK_EN_O);
  c_tmr: cover property (run && sel == 4'h4 && BASE_CLK_EN_O);
  c_rsv: cover property (SEL_RESERVED_O);
endmodule : base_clock_ratio_sel_asserts
bind base_clock_ratio_sel_top base_clock_ratio_sel_asserts u_chk (.*);

// [tb/base_clock_ratio_sel_peer.sv]
// Purpose: Model of the external clock source and timer outputs
// Assumes: Driven off the falling edge
// Notes:   pin_o and ch0_a rest low when stopped; ch0_c is tied low, ch1_a and ch2_a tied high
`timescale 1ns/1ps
module base_clock_ratio_sel_peer
  import base_clock_ratio_sel_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  run_i,
  output logic       pin_o,
  output base_clock_ratio_sel_timer_t tmr_o
);
  logic [3:0] cnt_reg = 4'h0;
  logic       sq_reg  = 1'b0;
  always @(negedge clk_i) begin
    cnt_reg <= (!run_i || cnt_reg == 4'h9) ? 4'h0 : cnt_reg + 4'h1;
    if (!run_i) sq_reg <= 1'b0;
    else if (cnt_reg == 4'h9) sq_reg <= !sq_reg;
  end
  assign pin_o = sq_reg;
  assign tmr_o = '{ch0_a: sq_reg, ch0_c: 1'b0, ch1_a: 1'b1, ch2_a: 1'b1};
endmodule : base_clock_ratio_sel_peer

// [tb/base_clock_ratio_sel_top_tb.sv]
// Purpose: Self-checking bench for base_clock_ratio_sel_top
// Assumes: Peer model toggles pins every 10 cycles
// Notes:   Pulse counts checked per select code
`timescale 1ns/1ps
module base_clock_ratio_sel_top_tb;
  import base_clock_ratio_sel_pkg::*;
  typedef struct {logic [3:0] sel; logic r8; logic rsv; logic ta; int cnt;} base_clock_ratio_sel_note_t;
  localparam int N = 4000;
  logic CORE_CLK_I = 1'b0, RST_N_I = 1'b0, ASYNC_SRC_SEL_MSB_I = 1'b0, run = 1'b0;
  logic BASE_CLOCK_RATIO_SEL_I = 1'b0, EXT_CLOCK_INPUT_SEL_I = 1'b1, SYNC_ASYNC_SELECT_I = 1'b0;
  logic [2:0] ASYNC_SRC_SEL_LOW_I = 3'h0;
  logic EXT_CLK_PIN_I, BASE_CLK_EN_O, RATIO_8X_O, TIMER_SRC_ACTIVE_O, SEL_RESERVED_O;
  logic [3:0] ASYNC_SRC_SEL_O;
  base_clock_ratio_sel_timer_t TIMER_OUT_I;
  base_clock_ratio_sel_note_t notes[$];
  int cnt, cyc, num_errors, n_tests;
  event snap;
  longint rt[16] = '{0, 115152, 460606, 921569, 0, 115196, 460784, 720000,
                     115132, 460526, 720000, 921053, 0, 0, 0, 0};
  base_clock_ratio_sel_top DUT (.*);
  base_clock_ratio_sel_peer u_peer (.clk_i(CORE_CLK_I), .run_i(run), .pin_o(EXT_CLK_PIN_I), .tmr_o(TIMER_OUT_I));
  initial forever #2.5 CORE_CLK_I = !CORE_CLK_I;
  task automatic results();
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input logic [3:0] s, input logic ex, input logic sy);
    base_clock_ratio_sel_note_t n;
    logic m8;
    m8 = s inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB};
    @(negedge CORE_CLK_I);
    {ASYNC_SRC_SEL_MSB_I, ASYNC_SRC_SEL_LOW_I} = s;
    BASE_CLOCK_RATIO_SEL_I = 1'($urandom);
    EXT_CLOCK_INPUT_SEL_I = ex;
    SYNC_ASYNC_SELECT_I = sy;
    run = (s & 4'hB) == 4'h0;
    repeat (16) @(negedge CORE_CLK_I);
    cnt = 0;
    repeat (N) @(negedge CORE_CLK_I);
    n.sel = s;
    n.rsv = s[3:2] == 2'h3;
    n.r8 = run ? BASE_CLOCK_RATIO_SEL_I : m8;
    n.ta = ex && !sy && s == 4'h4;
    n.cnt = (!ex || sy || n.rsv) ? 0 : run ? N / 20 : rt[s] * (m8 ? 8 : 16) * N / 200000000;
    notes.push_back(n);
    ->snap;
  endtask : step
  always @(posedge CORE_CLK_I) if (BASE_CLK_EN_O === 1'b1) cnt++;
  always @(posedge CORE_CLK_I) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      results();
    end
  end
  initial forever begin
    base_clock_ratio_sel_note_t n;
    @(snap);
    n = notes.pop_front();
    check(32'(ASYNC_SRC_SEL_O), 32'(n.sel));
    check(32'(SEL_RESERVED_O), 32'(n.rsv));
    if (!n.rsv) check(32'(RATIO_8X_O), 32'(n.r8));
    check(32'(TIMER_SRC_ACTIVE_O), 32'(n.ta));
    check((cnt >= n.cnt - 1 && cnt <= n.cnt + 1) ? n.cnt : cnt, n.cnt);
  end
  initial begin
    void'($urandom(55));
    repeat (4) @(negedge CORE_CLK_I);
    RST_N_I = 1'b1;
    repeat (4) @(negedge CORE_CLK_I);
    for (int i = 0; i < 16; i++) step(i[3:0], 1'b1, 1'b0);
    step(4'h1, 1'b0, 1'b0);
    step(4'h0, 1'b1, 1'b1);
    repeat (4) @(negedge CORE_CLK_I);
    results();
  end
endmodule : base_clock_ratio_sel_top_tb
